// ---- verilog/vbi_top.sv ----
// Operation
// - Drive 16 MHz system clock, jumper removable
// - AC fail follows power-on reset
// - System reset while processor reset active
// - Bus reset on power-on, processor, watchdog
// - Arbitrate requests by level daisy chain
// - Request bus when CPU needs it
// - Keep bus until another master requests
// - Latch acknowledge or error, report to CPU
// - Rerun on access timeout or deadlock
// - Deadlock: CPU access during slave access
// - Freeze interface, rerun, then resume access
// - Reruns invisible, allowed while awaiting grant
// - Rerun gives CPU bus error and halt
// - Timeout flag after 128 reruns
// - Slave pending only when all conditions hold
// - Pending access requests on-board DVMA fetch
// - Pass write data, latch read data
// - Handshake on trailing edge of enable
// - Pending held until data strobes negate
// - Clear handshake on pending falling edge
// - Encode seven lines, merge with on-board
// - Acknowledged level checked against bus lines
//
// Purpose: Backplane bus master, slave, utilities and interrupts
// Assumes: Backplane pins active high after receivers
// Notes: Rerun ends when the CPU drops its access request
`timescale 1ns/1ps
module vbi_top (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_por,
   input wire logic i_cpu_reset,
   input wire logic i_watchdog_reset,
   input wire logic i_sysclk_jumper,
   input wire logic i_cpu_wants_backplane,
   input wire logic [vbi_pkg::REQ_N-1:0] i_bus_req_lines,
   input wire logic i_grant_in,
   input wire logic i_dtack,
   input wire logic i_berr,
   input wire logic [vbi_pkg::UPPER_W-1:0] i_backplane_upper_addr,
   input wire logic [vbi_pkg::UPPER_W-1:0] i_switch_base_bits,
   input wire logic i_am_valid,
   input wire logic i_backplane_int_ack,
   input wire logic i_slave_addr_strobe_in,
   input wire logic i_slave_upper_strobe_in,
   input wire logic i_slave_lower_strobe_in,
   input wire logic i_backplane_write,
   input wire logic [vbi_pkg::ADDR_W-1:0] i_backplane_addr,
   input wire logic [vbi_pkg::DATA_W-1:0] i_backplane_data,
   input wire logic i_slave_dvma_enable,
   input wire logic i_dvma_error,
   input wire logic [vbi_pkg::DATA_W-1:0] i_mem_data,
   input wire logic [vbi_pkg::IRQ_N-1:0] i_backplane_int_lines,
   input wire logic [vbi_pkg::IRQ_N-1:0] i_int_jumper,
   input wire logic [vbi_pkg::LVL_W-1:0] i_onboard_level,
   input wire logic i_cpu_iack_cycle,
   input wire logic [vbi_pkg::LVL_W-1:0] i_cpu_iack_level,
   output logic o_sysclk,
   output logic o_acfail,
   output logic o_sysreset,
   output logic o_bus_reset_out,
   output logic o_bus_request,
   output logic o_bus_busy,
   output logic o_grant_out,
   output logic o_master_strobe,
   output logic o_cpu_ack,
   output logic o_cpu_berr,
   output logic o_cpu_halt,
   output logic o_rerun_timeout,
   output logic o_slave_dvma_request,
   output logic [vbi_pkg::ADDR_W-1:0] o_dvma_addr,
   output logic [vbi_pkg::DATA_W-1:0] o_local_data,
   output logic [vbi_pkg::DATA_W-1:0] o_backplane_data,
   output logic o_backplane_data_oe,
   output logic o_slave_ack_out,
   output logic o_slave_error_out,
   output logic [vbi_pkg::LVL_W-1:0] o_encoded_backplane_level,
   output logic [vbi_pkg::LVL_W-1:0] o_cpu_int_level,
   output logic o_iack_external
);
   import vbi_pkg::*;

   localparam int SYNC_W = 5 + REQ_N + 2 + 2 * UPPER_W + 5 + ADDR_W + DATA_W + IRQ_N;
   logic s_por, s_wd, s_jump, s_grant, s_dtack, s_berr, s_am, s_iack, s_as, s_uds, s_lds, s_wr;
   logic [REQ_N-1:0] s_req;
   logic [UPPER_W-1:0] s_upper, s_base;
   logic [ADDR_W-1:0] s_addr;
   logic [DATA_W-1:0] s_data;
   logic [IRQ_N-1:0] s_irq;

   // Backplane pins and straps, except the interrupt jumpers, cross in through two flops
   vbi_sync #(.W(SYNC_W)) u_sync (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_d({i_por, i_watchdog_reset, i_sysclk_jumper, i_grant_in, i_dtack, i_bus_req_lines, i_berr,
            i_am_valid, i_backplane_upper_addr, i_switch_base_bits, i_backplane_int_ack,
            i_slave_addr_strobe_in, i_slave_upper_strobe_in, i_slave_lower_strobe_in,
            i_backplane_write, i_backplane_addr, i_backplane_data,
            i_backplane_int_lines}),
      .o_q({s_por, s_wd, s_jump, s_grant, s_dtack, s_req, s_berr, s_am, s_upper, s_base, s_iack,
            s_as, s_uds, s_lds, s_wr, s_addr, s_data, s_irq})
   );

   // Utilities
   logic [8:0] acc, next_acc;
   logic next_sysclk;
   always_comb begin
      next_acc = acc + SYSCLK_STEP;
      next_sysclk = o_sysclk;
      // Fractional divider: 6.25 board cycles per half period, edges jitter by one cycle
      if (next_acc >= SYSCLK_MOD) begin
         next_acc = next_acc - SYSCLK_MOD;
         next_sysclk = ~o_sysclk;
      end
      if (!s_jump) begin
         next_sysclk = 1'b0;
      end
   end
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         acc <= '0;
         o_sysclk <= 1'b0;
         o_acfail <= 1'b0;
         o_sysreset <= 1'b0;
         o_bus_reset_out <= 1'b0;
      end else begin
         acc <= next_acc;
         o_sysclk <= next_sysclk;
         o_acfail <= s_por;
         o_sysreset <= i_cpu_reset;
         o_bus_reset_out <= s_por | i_cpu_reset | s_wd;
      end
   end

   // Master side
   typedef enum logic [2:0] {M_IDLE, M_REQ, M_OWN, M_XFER, M_RERUN} vbi_mst_e;
   vbi_mst_e st, next_st, resume, next_resume;
   logic [TIMER_W-1:0] timer, next_timer;
   logic [RERUN_W-1:0] reruns, next_reruns;
   logic next_req, next_busy, next_grant_out, next_strobe, next_ack, next_berr, next_halt;
   logic slave_pending;
   logic deadlock, expired, rerun_go;

   assign deadlock = i_cpu_wants_backplane & slave_pending;
   assign expired = (timer == TIMER_W'(ACCESS_LIMIT_CYC - 1));
   assign rerun_go = deadlock | expired;

   always_comb begin
      next_st = st;
      next_resume = resume;
      next_timer = '0;
      next_reruns = reruns;
      next_req = o_bus_request;
      next_busy = o_bus_busy;
      next_strobe = o_master_strobe;
      next_ack = 1'b0;
      next_berr = 1'b0;
      next_halt = 1'b0;
      // Level daisy chain: pass grant down unless we asked for it
      // Synced grant lingers after we take the bus, so never pass it on while busy
      next_grant_out = s_grant & ~o_bus_request & ~o_bus_busy;
      unique case (st)
         M_IDLE: begin
            if (i_cpu_wants_backplane) begin
               next_req = 1'b1;
               next_st = M_REQ;
            end
         end
         M_REQ: begin
            next_timer = timer + 1'b1;
            if (rerun_go) begin
               next_st = M_RERUN;
               next_resume = M_REQ;
            end else if (s_grant) begin
               next_req = 1'b0;
               next_busy = 1'b1;
               next_grant_out = 1'b0;
               next_strobe = 1'b1;
               next_timer = '0;
               next_st = M_XFER;
            end
         end
         M_OWN: begin
            // Want seen in the answer cycle still belongs to the access just ended
            if (i_cpu_wants_backplane && !o_cpu_ack && !o_cpu_berr) begin
               next_strobe = 1'b1;
               next_st = M_XFER;
            end else if (|s_req) begin
               next_busy = 1'b0;
               next_st = M_IDLE;
            end
         end
         M_XFER: begin
            next_timer = timer + 1'b1;
            if (s_dtack | s_berr) begin
               next_strobe = 1'b0;
               next_ack = s_dtack;
               next_berr = ~s_dtack & s_berr;
               next_reruns = '0;
               next_st = M_OWN;
            end else if (expired) begin
               next_st = M_RERUN;
               next_resume = M_XFER;
            end
         end
         M_RERUN: begin
            // Bus side outputs stay frozen; only the CPU sees the rerun
            next_halt = 1'b1;
            if (!i_cpu_wants_backplane) begin
               next_halt = 1'b0;
               next_st = resume;
            end
         end
      endcase
      if (st != M_RERUN && next_st == M_RERUN) begin
         next_berr = 1'b1;
         next_halt = 1'b1;
         if (reruns < RERUN_W'(RERUN_LIMIT)) begin
            next_reruns = reruns + 1'b1;
         end
      end
   end
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st <= M_IDLE;
         resume <= M_IDLE;
         timer <= '0;
         reruns <= '0;
         o_bus_request <= 1'b0;
         o_bus_busy <= 1'b0;
         o_grant_out <= 1'b0;
         o_master_strobe <= 1'b0;
         o_cpu_ack <= 1'b0;
         o_cpu_berr <= 1'b0;
         o_cpu_halt <= 1'b0;
         o_rerun_timeout <= 1'b0;
      end else begin
         st <= next_st;
         resume <= next_resume;
         timer <= next_timer;
         reruns <= next_reruns;
         o_bus_request <= next_req;
         o_bus_busy <= next_busy;
         o_grant_out <= next_grant_out;
         o_master_strobe <= next_strobe;
         o_cpu_ack <= next_ack;
         o_cpu_berr <= next_berr;
         o_cpu_halt <= next_halt;
         o_rerun_timeout <= (next_reruns >= RERUN_W'(RERUN_LIMIT));
      end
   end

   // Slave side
   logic strobes, match, dvma_en_d, pend_d;
   logic next_pending, next_ack_out, next_err_out, next_oe;
   logic [DATA_W-1:0] next_rd_data;
   logic [ADDR_W-1:0] next_addr;
   assign strobes = s_uds | s_lds;
   assign match = (s_upper == s_base) & s_am & ~s_iack & ~o_bus_busy & s_as & strobes;

   always_comb begin
      next_pending = match | (slave_pending & strobes);
      next_addr = o_dvma_addr;
      next_rd_data = o_backplane_data;
      next_ack_out = o_slave_ack_out;
      next_err_out = o_slave_error_out;
      next_oe = slave_pending & ~s_wr;
      if (next_pending & ~slave_pending) begin
         next_addr = s_addr;
      end
      if (dvma_en_d & ~i_slave_dvma_enable) begin
         next_ack_out = ~i_dvma_error;
         next_err_out = i_dvma_error;
         if (!s_wr) begin
            next_rd_data = i_mem_data;
         end
      end
      if (pend_d & ~slave_pending) begin
         next_ack_out = 1'b0;
         next_err_out = 1'b0;
      end
   end
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         slave_pending <= 1'b0;
         pend_d <= 1'b0;
         dvma_en_d <= 1'b0;
         o_slave_dvma_request <= 1'b0;
         o_dvma_addr <= '0;
         o_local_data <= '0;
         o_backplane_data <= '0;
         o_backplane_data_oe <= 1'b0;
         o_slave_ack_out <= 1'b0;
         o_slave_error_out <= 1'b0;
      end else begin
         slave_pending <= next_pending;
         pend_d <= slave_pending;
         dvma_en_d <= i_slave_dvma_enable;
         o_slave_dvma_request <= next_pending;
         o_dvma_addr <= next_addr;
         o_local_data <= s_data;
         o_backplane_data <= next_rd_data;
         o_backplane_data_oe <= next_oe;
         o_slave_ack_out <= next_ack_out;
         o_slave_error_out <= next_err_out;
      end
   end

   // Interrupts
   logic [IRQ_N-1:0] irq_sel;
   logic [LVL_W-1:0] next_enc, next_ipl;
   assign irq_sel = s_irq & i_int_jumper;
   always_comb begin
      next_enc = '0;
      for (int i = 0; i < IRQ_N; i++) begin
         if (irq_sel[i]) begin
            next_enc = LVL_W'(i + 1);
         end
      end
      next_ipl = (next_enc > i_onboard_level) ? next_enc : i_onboard_level;
   end
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_encoded_backplane_level <= '0;
         o_cpu_int_level <= '0;
         o_iack_external <= 1'b0;
      end else begin
         o_encoded_backplane_level <= next_enc;
         o_cpu_int_level <= next_ipl;
         o_iack_external <= i_cpu_iack_cycle && (i_cpu_iack_level != '0)
                            && irq_sel[i_cpu_iack_level - 1'b1];
      end
   end

   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   property p_reset_out;
      i_cpu_reset |=> o_bus_reset_out && o_sysreset;
   endproperty
   a_reset_out: assert property (p_reset_out) else $error("bus reset not raised");
   property p_req_on_want;
      st == M_IDLE && i_cpu_wants_backplane |=> o_bus_request;
   endproperty
   a_req_on_want: assert property (p_req_on_want) else $error("no bus request");
   property p_keep_bus;
      st == M_OWN && !i_cpu_wants_backplane && !(|s_req) |=> o_bus_busy;
   endproperty
   a_keep_bus: assert property (p_keep_bus) else $error("bus released unasked");
   property p_ack_pass;
      st == M_XFER && s_dtack |=> o_cpu_ack && !o_master_strobe;
   endproperty
   a_ack_pass: assert property (p_ack_pass) else $error("ack not passed");
   property p_timeout;
      st == M_XFER && !s_dtack && !s_berr && expired |=> st == M_RERUN && o_cpu_berr && o_cpu_halt;
   endproperty
   a_timeout: assert property (p_timeout) else $error("no rerun on timeout");
   property p_frozen;
      st == M_RERUN && $past(st) == M_RERUN |-> $stable(o_master_strobe) && $stable(o_bus_request);
   endproperty
   a_frozen: assert property (p_frozen) else $error("bus moved during rerun");
   property p_limit;
      reruns == RERUN_W'(RERUN_LIMIT - 1) && st != M_RERUN && next_st == M_RERUN |=> o_rerun_timeout;
   endproperty
   a_limit: assert property (p_limit) else $error("timeout not flagged");
   property p_pend_hold;
      slave_pending && strobes |=> slave_pending;
   endproperty
   a_pend_hold: assert property (p_pend_hold) else $error("pending dropped early");
   property p_hs_clear;
      pend_d && !slave_pending |=> !o_slave_ack_out && !o_slave_error_out;
   endproperty
   a_hs_clear: assert property (p_hs_clear) else $error("handshake not cleared");
   property p_no_slave_when_master;
      o_bus_busy && !slave_pending |=> !slave_pending;
   endproperty
   a_no_slave_when_master: assert property (p_no_slave_when_master) else $error("slave while master");
   c_xfer: cover property (st == M_XFER ##[1:20] o_cpu_ack);
   c_rerun: cover property (st == M_RERUN ##1 st == M_XFER);
   c_slave: cover property (slave_pending ##[1:30] o_slave_ack_out);
endmodule // vbi_top

// ---- verilog/vbi_pkg.sv ----
// Purpose: Shared constants for the backplane bus interface
// Assumes: 200 MHz board clock
// Notes: Timing counts derive from times in their own units
package vbi_pkg;
   localparam int CLK_MHZ = 200;
   localparam int SYSCLK_MHZ = 16;
   // Toggle step of the system clock phase accumulator
   localparam logic [8:0] SYSCLK_STEP = 9'(2 * SYSCLK_MHZ);
   localparam logic [8:0] SYSCLK_MOD = 9'(CLK_MHZ);
   // Least access time before a rerun, in ns
   localparam int ACCESS_LIMIT_NS = 2000;
   localparam int ACCESS_LIMIT_CYC = (ACCESS_LIMIT_NS * CLK_MHZ + 999) / 1000;
   localparam int TIMER_W = 10;
   localparam int RERUN_LIMIT = 128;
   localparam int RERUN_W = 8;
   localparam int UPPER_W = 4;
   localparam int ADDR_W = 23;
   localparam int DATA_W = 16;
   localparam int IRQ_N = 7;
   localparam int LVL_W = 3;
   localparam int REQ_N = 4;
endpackage

// ---- verilog/vbi_sync.sv ----
// Purpose: Two-flop synchroniser for a vector of pins
// Assumes: Bits are independent levels
// Notes: Only the second stage may be read
`timescale 1ns/1ps
module vbi_sync #(
   parameter int W = 1
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] meta;
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         meta <= '0;
         o_q <= '0;
      end else begin
         meta <= i_d;
         o_q <= meta;
      end
   end
endmodule // vbi_sync

// ---- dv/vbi_far_model.sv ----
// Purpose: Far side of the backplane: arbiter grant and addressed slave
// Assumes: Lines active high after receivers, idle low when released
// Notes: Answer delay, kind and silence are set by the bench
`timescale 1ns/1ps
module vbi_far_model (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_bus_request,
   input wire logic i_master_strobe,
   input wire logic [7:0] i_delay,
   input wire logic i_mute,
   input wire logic i_use_berr,
   output logic o_grant,
   output logic o_dtack,
   output logic o_berr
);
   logic [7:0] wait_cnt;
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_grant <= 1'h0;
         o_dtack <= 1'h0;
         o_berr <= 1'h0;
         wait_cnt <= 8'h00;
      end else begin
         o_grant <= i_bus_request;
         // Released answer lines fall back to their idle level
         if (!i_master_strobe) begin
            wait_cnt <= 8'h00;
            o_dtack <= 1'h0;
            o_berr <= 1'h0;
         end else if (wait_cnt < i_delay) begin
            wait_cnt <= wait_cnt + 8'h01;
         end else if (!i_mute) begin
            o_dtack <= !i_use_berr;
            o_berr <= i_use_berr;
         end
      end
   end
endmodule // vbi_far_model

// ---- dv/tb_vbi_top.sv ----
// Purpose: Self-checking bench for the backplane bus interface
// Assumes: Far side modelled by vbi_far_model
// Notes: Full 128-rerun run dominates the cycle count
`timescale 1ns/1ps
module tb_vbi_top;
   import vbi_pkg::*;
   logic i_clk, i_resetn, i_por, i_cpu_reset, i_watchdog_reset, i_sysclk_jumper, i_cpu_wants_backplane, i_grant_in;
   logic i_dtack, i_berr, i_am_valid, i_backplane_int_ack, i_slave_addr_strobe_in, i_slave_upper_strobe_in;
   logic i_slave_lower_strobe_in, i_backplane_write, i_slave_dvma_enable, i_dvma_error, i_cpu_iack_cycle;
   logic [REQ_N-1:0] i_bus_req_lines;
   logic [UPPER_W-1:0] i_backplane_upper_addr, i_switch_base_bits;
   logic [ADDR_W-1:0] i_backplane_addr, o_dvma_addr;
   logic [DATA_W-1:0] i_backplane_data, i_mem_data, o_local_data, o_backplane_data;
   logic [IRQ_N-1:0] i_backplane_int_lines, i_int_jumper;
   logic [LVL_W-1:0] i_onboard_level, i_cpu_iack_level, o_encoded_backplane_level, o_cpu_int_level;
   logic o_sysclk, o_acfail, o_sysreset, o_bus_reset_out, o_bus_request, o_bus_busy, o_grant_out, o_master_strobe;
   logic o_cpu_ack, o_cpu_berr, o_cpu_halt, o_rerun_timeout, o_slave_dvma_request, o_backplane_data_oe;
   logic o_slave_ack_out, o_slave_error_out, o_iack_external;
   logic [7:0] far_delay;
   logic far_mute, far_berr, got_ack, got_err, got_halt, got_strobe, saw_req, saw_pass, prev_clk;
   int miscompares, comparisons, cycles, n, k, edges;
   logic [27:0] rows [8];

   vbi_top i_dut (.*);
   vbi_far_model i_far (.i_clk(i_clk), .i_resetn(i_resetn), .i_bus_request(o_bus_request),
      .i_master_strobe(o_master_strobe), .i_delay(far_delay), .i_mute(far_mute), .i_use_berr(far_berr),
      .o_grant(i_grant_in), .o_dtack(i_dtack), .o_berr(i_berr));

   initial begin
      i_clk = 1'h0;
      forever #2.5 i_clk = !i_clk;
   end

   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 90000) begin
         miscompares++;
         conclude();
      end
   end

   task automatic conclude();
      $display("Counts: comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tick(input int c);
      repeat (c) @(posedge i_clk);
      #1;
   endtask

   // CPU holds its request until acknowledge or error, then drops it
   task automatic cpu_access(input logic [7:0] dly, input logic use_berr);
      @(posedge i_clk);
      far_delay <= dly;
      far_berr <= use_berr;
      i_cpu_wants_backplane <= 1'h1;
      saw_req = 1'h0;
      saw_pass = 1'h0;
      for (n = 0; n < 600 && o_cpu_ack !== 1'h1 && o_cpu_berr !== 1'h1; n++) begin
         tick(1);
         if (o_bus_request === 1'h1) saw_req = 1'h1;
         if (o_grant_out === 1'h1) saw_pass = 1'h1;
      end
      got_ack = o_cpu_ack;
      got_err = o_cpu_berr;
      got_halt = o_cpu_halt;
      got_strobe = o_master_strobe;
      @(posedge i_clk);
      i_cpu_wants_backplane <= 1'h0;
   endtask

   task automatic slave_pins(input logic [3:0] up, input logic am, input logic iack, input logic strb);
      @(posedge i_clk);
      i_backplane_upper_addr <= up;
      i_am_valid <= am;
      i_backplane_int_ack <= iack;
      i_slave_addr_strobe_in <= strb;
      i_slave_upper_strobe_in <= strb;
      i_slave_lower_strobe_in <= strb;
   endtask

   task automatic slave_cycle(input logic wr, input logic err);
      @(posedge i_clk);
      i_backplane_write <= wr;
      slave_pins(4'h9, 1'h1, 1'h0, 1'h1);
      tick(6);
      check("dvma_request", o_slave_dvma_request, 1'h1);
      check("dvma_addr", o_dvma_addr, 23'h012345);
      if (wr) check("local_data", o_local_data, 16'ha5c3);
      @(posedge i_clk);
      i_slave_dvma_enable <= 1'h1;
      i_dvma_error <= err;
      repeat (3) @(posedge i_clk);
      i_slave_dvma_enable <= 1'h0;
      tick(4);
      check("slave_ack", o_slave_ack_out, !err);
      check("slave_err", o_slave_error_out, err);
      if (!wr) check("bp_data", o_backplane_data, 16'h3c5a);
      if (!wr) check("bp_oe", o_backplane_data_oe, 1'h1);
      tick(5);
      check("pending_held", o_slave_dvma_request, 1'h1);
      slave_pins(4'h9, 1'h1, 1'h0, 1'h0);
      for (n = 0; n < 12 && o_slave_dvma_request !== 1'h0; n++) tick(1);
      tick(2);
      check("ack_cleared", {o_slave_ack_out, o_slave_error_out}, 2'h0);
      $display("Slave cycle write=%0d error=%0d done", wr, err);
   endtask

   initial begin
      // lines, jumper, onboard, iack, iack level, encoded, cpu level, external
      rows = '{{7'h00, 7'h7f, 3'h0, 1'h0, 3'h0, 3'h0, 3'h0, 1'h0}, {7'h01, 7'h7f, 3'h0, 1'h1, 3'h1, 3'h1, 3'h1, 1'h1},
               {7'h40, 7'h7f, 3'h2, 1'h1, 3'h7, 3'h7, 3'h7, 1'h1}, {7'h40, 7'h3f, 3'h2, 1'h1, 3'h7, 3'h0, 3'h2, 1'h0},
               {7'h14, 7'h7f, 3'h3, 1'h1, 3'h3, 3'h5, 3'h5, 1'h1}, {7'h14, 7'h7f, 3'h6, 1'h1, 3'h4, 3'h5, 3'h6, 1'h0},
               {7'h7f, 7'h55, 3'h0, 1'h0, 3'h7, 3'h7, 3'h7, 1'h0}, {7'h22, 7'h7f, 3'h7, 1'h1, 3'h2, 3'h6, 3'h7, 1'h1}};
      {i_por, i_cpu_reset, i_watchdog_reset, i_sysclk_jumper, i_cpu_wants_backplane, i_bus_req_lines, i_am_valid,
       i_backplane_int_ack, i_slave_addr_strobe_in, i_slave_upper_strobe_in, i_slave_lower_strobe_in,
       i_slave_dvma_enable, i_dvma_error, i_backplane_int_lines, i_int_jumper, i_onboard_level, i_cpu_iack_cycle,
       i_cpu_iack_level, far_mute, far_berr, far_delay} = '0;
      i_resetn = 1'h0;
      i_backplane_write = 1'h1;
      i_switch_base_bits = 4'h9;
      i_backplane_upper_addr = 4'h0;
      i_backplane_addr = 23'h012345;
      i_backplane_data = 16'ha5c3;
      i_mem_data = 16'h3c5a;
      repeat (8) @(posedge i_clk);
      i_resetn <= 1'h1;
      tick(4);
      for (k = 0; k < 8; k++) begin
         @(posedge i_clk);
         {i_backplane_int_lines, i_int_jumper, i_onboard_level, i_cpu_iack_cycle, i_cpu_iack_level} <= rows[k][27:7];
         tick(7);
         check("encoded_level", o_encoded_backplane_level, rows[k][6:4]);
         check("cpu_level", o_cpu_int_level, rows[k][3:1]);
         check("iack_external", o_iack_external, rows[k][0]);
      end
      $display("Interrupt table done");
      for (k = 0; k < 3; k++) begin
         @(posedge i_clk);
         {i_por, i_cpu_reset, i_watchdog_reset} <= 3'h4 >> k;
         tick(6);
         check("acfail", o_acfail, k == 0);
         check("sysreset", o_sysreset, k == 1);
         check("bus_reset_out", o_bus_reset_out, 1'h1);
      end
      @(posedge i_clk);
      {i_por, i_cpu_reset, i_watchdog_reset, i_sysclk_jumper} <= 4'h1;
      tick(10);
      for (k = 0; k < 2; k++) begin
         edges = 0;
         prev_clk = o_sysclk;
         repeat (200) begin
            tick(1);
            if (o_sysclk === 1'h1 && prev_clk === 1'h0) edges++;
            prev_clk = o_sysclk;
         end
         check("sysclk_edges", edges >= 15 && edges <= 17, k == 0);
         @(posedge i_clk);
         i_sysclk_jumper <= 1'h0;
         tick(10);
      end
      $display("Utility lines done");
      cpu_access(8'h00, 1'h0);
      check("first_ack", {got_ack, got_err, saw_req}, 3'h5);
      check("grant_blocked", saw_pass, 1'h0);
      tick(3);
      check("busy_kept", o_bus_busy, 1'h1);
      cpu_access(8'h14, 1'h1);
      check("slow_berr", {got_ack, got_err, got_halt, saw_req}, 4'h4);
      far_mute <= 1'h1;
      for (k = 1; k <= 128; k++) begin
         cpu_access(8'h00, 1'h0);
         if (k == 1) check("rerun", {got_err, got_halt, got_strobe}, 3'h7);
         tick(3);
         if (k == 1) check("halt_end", o_cpu_halt, 1'h0);
         if (k >= 127) check("rerun_timeout", o_rerun_timeout, k == 128);
      end
      @(posedge i_clk);
      far_mute <= 1'h0;
      cpu_access(8'h00, 1'h0);
      tick(3);
      check("resumed", {got_ack, o_rerun_timeout}, 2'h2);
      $display("Master and rerun done");
      slave_pins(4'h9, 1'h1, 1'h0, 1'h1);
      tick(6);
      check("master_no_slave", o_slave_dvma_request, 1'h0);
      slave_pins(4'h9, 1'h1, 1'h0, 1'h0);
      i_bus_req_lines <= 4'h2;
      tick(8);
      check("busy_released", o_bus_busy, 1'h0);
      @(posedge i_clk);
      i_bus_req_lines <= 4'h0;
      for (k = 0; k < 3; k++) begin
         slave_pins(k == 0 ? 4'h6 : 4'h9, k != 1, k == 2, 1'h1);
         tick(6);
         check("no_pending", o_slave_dvma_request, 1'h0);
         slave_pins(4'h9, 1'h1, 1'h0, 1'h0);
         tick(4);
      end
      slave_cycle(1'h1, 1'h0);
      slave_cycle(1'h0, 1'h1);
      slave_pins(4'h9, 1'h1, 1'h0, 1'h1);
      tick(6);
      @(posedge i_clk);
      i_cpu_wants_backplane <= 1'h1;
      for (n = 0; n < 12 && o_cpu_berr !== 1'h1; n++) tick(1);
      check("deadlock", {o_cpu_berr, o_cpu_halt}, 2'h3);
      @(posedge i_clk);
      i_cpu_wants_backplane <= 1'h0;
      slave_pins(4'h9, 1'h1, 1'h0, 1'h0);
      tick(8);
      cpu_access(8'h00, 1'h0);
      check("after_deadlock", got_ack, 1'h1);
      $display("Deadlock done");
      conclude();
   end
endmodule // tb_vbi_top
